// ===== axis_id_power_up_select.sv
`timescale 1ns/1ps
`default_nettype none

module axis_id_power_up_select #(
  parameter int SWITCH_BANK_WIDTH = 4,
  parameter int AXIS_INDEX_WIDTH  = 3
) (
  input  wire logic                         aclk,                    // System clock, 125 MHz.
  input  wire logic                         aresetn,                 // Synchronous reset, active low.
  input  wire logic [SWITCH_BANK_WIDTH-1:0] low_selector_switch_bank, // Contacts 1..4 in bits 0..3, on = 1.
  input  wire logic                         high_selector_switch,    // High contact, on = 1.
  input  wire logic [AXIS_INDEX_WIDTH-1:0]  axis_position,           // Strap, axis position 1..4.
  output logic [7:0]                        node_identifier,         // Active node identifier.
  output logic                              protocol_vendor_can,     // 1 = vendor CAN, 0 = CANopen.
  output logic                              lss_inactive,            // LSS inactive state.
  output logic [15:0]                       station_alias,           // Configured station alias.
  output logic                              config_done,             // Power-up decode finished.
  input  wire logic [7:0]                   s_axi_awaddr,            // Write address.
  input  wire logic                         s_axi_awvalid,           // Write address valid.
  output logic                              s_axi_awready,           // Write address ready.
  input  wire logic [31:0]                  s_axi_wdata,             // Write data.
  input  wire logic [3:0]                   s_axi_wstrb,             // Write byte strobes.
  input  wire logic                         s_axi_wvalid,            // Write data valid.
  output logic                              s_axi_wready,            // Write data ready.
  output logic [1:0]                        s_axi_bresp,             // Write response.
  output logic                              s_axi_bvalid,            // Write response valid.
  input  wire logic                         s_axi_bready,            // Write response ready.
  input  wire logic [7:0]                   s_axi_araddr,            // Read address.
  input  wire logic                         s_axi_arvalid,           // Read address valid.
  output logic                              s_axi_arready,           // Read address ready.
  output logic [31:0]                       s_axi_rdata,             // Read data.
  output logic [1:0]                        s_axi_rresp,             // Read response.
  output logic                              s_axi_rvalid,            // Read data valid.
  input  wire logic                         s_axi_rready             // Read data ready.
);

  localparam int SYNC_WIDTH = SWITCH_BANK_WIDTH + 1 + AXIS_INDEX_WIDTH;
  localparam int CNT_WIDTH  = $clog2(node_id_pkg::SETTLE_CYCLES + 1);

  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  // Three stages; a level counts only once the second and third agree.
  logic [SYNC_WIDTH-1:0] sync1_reg;
  logic [SYNC_WIDTH-1:0] sync2_reg;
  logic [SYNC_WIDTH-1:0] sync3_reg;
  logic                  inputs_stable;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end else begin
      sync1_reg <= {axis_position, high_selector_switch, low_selector_switch_bank};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign inputs_stable = (sync2_reg == sync3_reg);

  // ---------------------------------------------------------------------------
  // Power-up sequence and identifier decode
  // ---------------------------------------------------------------------------
  node_id_pkg::power_state_t            state_reg, state_next;
  logic [CNT_WIDTH-1:0]                 settle_cnt_reg, settle_cnt_next;
  logic [SWITCH_BANK_WIDTH-1:0]         bank_sample_reg, bank_sample_next;
  logic                                 high_sample_reg, high_sample_next;
  logic [AXIS_INDEX_WIDTH-1:0]          axis_sample_reg, axis_sample_next;
  logic [7:0]                           node_id_reg, node_id_next;
  logic                                 vendor_can_reg, vendor_can_next;
  logic                                 lss_inactive_reg, lss_inactive_next;
  logic [15:0]                          alias_reg, alias_next;
  logic                                 done_reg, done_next;
  logic                                 hw_source_reg, hw_source_next;
  logic                                 setup_valid_reg, setup_valid_next;
  logic [7:0]                           soft_id_reg, soft_id_next;
  logic                                 apply_pulse;
  logic [7:0]                           switch_id;
  logic [7:0]                           chosen_id;
  logic [4:0]                           switch_code;
  logic [1:0]                           axis_offset;

  // Contact 1 is the most significant of the low bank, contact 4 the least.
  always_comb begin
    switch_code = {high_sample_reg, bank_sample_reg[0], bank_sample_reg[1], bank_sample_reg[2],
                   bank_sample_reg[3]};
    axis_offset = 2'(axis_sample_reg - AXIS_INDEX_WIDTH'(1));
    switch_id   = 8'({switch_code, 3'h0}) + {6'h00, axis_offset} + 8'h01;
    chosen_id   = (hw_source_reg || !setup_valid_reg) ? switch_id : soft_id_reg;
  end

  always_comb begin
    state_next        = state_reg;
    settle_cnt_next   = settle_cnt_reg;
    bank_sample_next  = bank_sample_reg;
    high_sample_next  = high_sample_reg;
    axis_sample_next  = axis_sample_reg;
    node_id_next      = node_id_reg;
    vendor_can_next   = vendor_can_reg;
    lss_inactive_next = lss_inactive_reg;
    alias_next        = alias_reg;
    done_next         = done_reg;
    case (state_reg)
      node_id_pkg::PWR_SETTLE: begin
        if (settle_cnt_reg == CNT_WIDTH'(node_id_pkg::SETTLE_CYCLES)) begin
          state_next = node_id_pkg::PWR_SAMPLE;
        end else begin
          settle_cnt_next = settle_cnt_reg + CNT_WIDTH'(1);
        end
      end
      node_id_pkg::PWR_SAMPLE: begin
        // The only capture of the switches; nothing later looks at them again.
        if (inputs_stable) begin
          bank_sample_next = sync3_reg[SWITCH_BANK_WIDTH-1:0];
          high_sample_next = sync3_reg[SWITCH_BANK_WIDTH];
          axis_sample_next = sync3_reg[SYNC_WIDTH-1 -: AXIS_INDEX_WIDTH];
          state_next       = node_id_pkg::PWR_DECODE;
        end
      end
      node_id_pkg::PWR_DECODE: begin
        node_id_next      = chosen_id;
        vendor_can_next   = high_sample_reg;
        lss_inactive_next = !high_sample_reg && (chosen_id == node_id_pkg::DEFAULT_NODE_ID);
        alias_next        = (chosen_id == node_id_pkg::DEFAULT_NODE_ID) ?
                            node_id_pkg::DEFAULT_ALIAS : {8'h00, chosen_id};
        done_next         = 1'b1;
        state_next        = node_id_pkg::PWR_DONE;
      end
      node_id_pkg::PWR_DONE: begin
        // A new setup is applied against the stored power-up samples only.
        if (apply_pulse) begin
          state_next = node_id_pkg::PWR_DECODE;
        end
      end
      default: begin
        state_next = node_id_pkg::PWR_SETTLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg        <= node_id_pkg::PWR_SETTLE;
      settle_cnt_reg   <= '0;
      bank_sample_reg  <= '0;
      high_sample_reg  <= 1'b0;
      axis_sample_reg  <= '0;
      node_id_reg      <= node_id_pkg::DEFAULT_NODE_ID;
      vendor_can_reg   <= 1'b0;
      lss_inactive_reg <= 1'b1;
      alias_reg        <= node_id_pkg::DEFAULT_ALIAS;
      done_reg         <= 1'b0;
    end else begin
      state_reg        <= state_next;
      settle_cnt_reg   <= settle_cnt_next;
      bank_sample_reg  <= bank_sample_next;
      high_sample_reg  <= high_sample_next;
      axis_sample_reg  <= axis_sample_next;
      node_id_reg      <= node_id_next;
      vendor_can_reg   <= vendor_can_next;
      lss_inactive_reg <= lss_inactive_next;
      alias_reg        <= alias_next;
      done_reg         <= done_next;
    end
  end

  assign node_identifier     = node_id_reg;
  assign protocol_vendor_can = vendor_can_reg;
  assign lss_inactive        = lss_inactive_reg;
  assign station_alias       = alias_reg;
  assign config_done         = done_reg;

  // ---------------------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------------------
  logic        awready_reg, awready_next;
  logic        wready_reg, wready_next;
  logic        aw_held_reg, aw_held_next;
  logic        w_held_reg, w_held_next;
  logic [7:0]  waddr_reg, waddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0]  wstrb_reg, wstrb_next;
  logic        bvalid_reg, bvalid_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic        arready_reg, arready_next;
  logic        rvalid_reg, rvalid_next;
  logic [1:0]  rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [7:0]  soft_id_field;

  always_comb begin
    awready_next     = awready_reg;
    wready_next      = wready_reg;
    aw_held_next     = aw_held_reg;
    w_held_next      = w_held_reg;
    waddr_next       = waddr_reg;
    wdata_next       = wdata_reg;
    wstrb_next       = wstrb_reg;
    bvalid_next      = bvalid_reg;
    bresp_next       = bresp_reg;
    arready_next     = arready_reg;
    rvalid_next      = rvalid_reg;
    rresp_next       = rresp_reg;
    rdata_next       = rdata_reg;
    hw_source_next   = hw_source_reg;
    setup_valid_next = setup_valid_reg;
    soft_id_next     = soft_id_reg;
    apply_pulse      = 1'b0;
    soft_id_field    = wdata_reg[node_id_pkg::SETUP_ID_LSB +: 8];

    if (s_axi_awvalid && awready_reg) begin
      waddr_next   = s_axi_awaddr;
      aw_held_next = 1'b1;
      awready_next = 1'b0;
    end
    if (s_axi_wvalid && wready_reg) begin
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
      w_held_next = 1'b1;
      wready_next = 1'b0;
    end
    // Both halves are held; commit the write one cycle after the later one arrives.
    if (aw_held_reg && w_held_reg && !bvalid_reg) begin
      bvalid_next  = 1'b1;
      bresp_next   = node_id_pkg::RESP_OKAY;
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      case (waddr_reg)
        node_id_pkg::SETUP_OFFSET: begin
          if (wstrb_reg[0]) begin
            hw_source_next   = wdata_reg[node_id_pkg::SETUP_HW_SOURCE_BIT];
            setup_valid_next = wdata_reg[node_id_pkg::SETUP_VALID_BIT];
          end
          // Zero is outside the accepted range and leaves the stored value alone.
          if (wstrb_reg[1] && (soft_id_field >= node_id_pkg::MIN_SOFT_NODE_ID)) begin
            soft_id_next = soft_id_field;
          end
        end
        node_id_pkg::COMMAND_OFFSET: begin
          apply_pulse = wstrb_reg[0] && wdata_reg[node_id_pkg::COMMAND_APPLY_BIT];
        end
        default: begin
          bresp_next = node_id_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next  = 1'b0;
      awready_next = 1'b1;
      wready_next  = 1'b1;
    end

    if (s_axi_arvalid && arready_reg) begin
      arready_next = 1'b0;
      rvalid_next  = 1'b1;
      rresp_next   = node_id_pkg::RESP_OKAY;
      case (s_axi_araddr)
        node_id_pkg::SETUP_OFFSET: begin
          rdata_next = {16'h0000, soft_id_reg, 6'h00, setup_valid_reg, hw_source_reg};
        end
        node_id_pkg::COMMAND_OFFSET: begin
          rdata_next = 32'h0000_0000;
        end
        node_id_pkg::STATUS_OFFSET: begin
          rdata_next = {16'h0000, node_id_reg, 5'h00, lss_inactive_reg, vendor_can_reg, done_reg};
        end
        node_id_pkg::SAMPLE_OFFSET: begin
          rdata_next = {16'h0000, 5'(axis_sample_reg), 6'h00, high_sample_reg, 4'(bank_sample_reg)};
        end
        node_id_pkg::ALIAS_OFFSET: begin
          rdata_next = {16'h0000, alias_reg};
        end
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = node_id_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next  = 1'b0;
      arready_next = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg     <= 1'b1;
      wready_reg      <= 1'b1;
      aw_held_reg     <= 1'b0;
      w_held_reg      <= 1'b0;
      waddr_reg       <= 8'h00;
      wdata_reg       <= 32'h0000_0000;
      wstrb_reg       <= 4'h0;
      bvalid_reg      <= 1'b0;
      bresp_reg       <= node_id_pkg::RESP_OKAY;
      arready_reg     <= 1'b1;
      rvalid_reg      <= 1'b0;
      rresp_reg       <= node_id_pkg::RESP_OKAY;
      rdata_reg       <= 32'h0000_0000;
      hw_source_reg   <= 1'b0;
      // An invalid setup after reset makes the switches the source.
      setup_valid_reg <= 1'b0;
      soft_id_reg     <= node_id_pkg::DEFAULT_NODE_ID;
    end else begin
      awready_reg     <= awready_next;
      wready_reg      <= wready_next;
      aw_held_reg     <= aw_held_next;
      w_held_reg      <= w_held_next;
      waddr_reg       <= waddr_next;
      wdata_reg       <= wdata_next;
      wstrb_reg       <= wstrb_next;
      bvalid_reg      <= bvalid_next;
      bresp_reg       <= bresp_next;
      arready_reg     <= arready_next;
      rvalid_reg      <= rvalid_next;
      rresp_reg       <= rresp_next;
      rdata_reg       <= rdata_next;
      hw_source_reg   <= hw_source_next;
      setup_valid_reg <= setup_valid_next;
      soft_id_reg     <= soft_id_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

endmodule // axis_id_power_up_select

`default_nettype wire

// ===== node_id_pkg.sv
package node_id_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] SETUP_OFFSET   = 8'h00;
  localparam logic [7:0] COMMAND_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET  = 8'h08;
  localparam logic [7:0] SAMPLE_OFFSET  = 8'h0C;
  localparam logic [7:0] ALIAS_OFFSET   = 8'h10;

  // SETUP and COMMAND fields.
  localparam int SETUP_HW_SOURCE_BIT = 0;
  localparam int SETUP_VALID_BIT     = 1;
  localparam int SETUP_ID_LSB        = 8;
  localparam int COMMAND_APPLY_BIT   = 0;

  // ---------------------------------------------------------------------------
  // Values
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  DEFAULT_NODE_ID   = 8'hFF;
  localparam logic [7:0]  MIN_SOFT_NODE_ID  = 8'h01;
  localparam logic [15:0] DEFAULT_ALIAS     = 16'h0000;
  localparam logic [2:0]  AXIS_STEP_SHIFT   = 3'h3;
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLOCK_PERIOD_PS = 8000;
  localparam int SETTLE_TIME_NS  = 1000;
  localparam int SETTLE_CYCLES   = (SETTLE_TIME_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;

  typedef enum logic [1:0] {
    PWR_SETTLE,
    PWR_SAMPLE,
    PWR_DECODE,
    PWR_DONE
  } power_state_t;

endpackage

// ===== axis_id_power_up_select_properties.sv
`timescale 1ns/1ps
`default_nettype none

module axis_id_power_up_select_properties #(
  parameter int SWITCH_BANK_WIDTH = 4,
  parameter int AXIS_INDEX_WIDTH  = 3
) (
  input wire logic                         aclk,                     // Clock.
  input wire logic                         aresetn,                  // Reset, active low.
  input wire logic [SWITCH_BANK_WIDTH-1:0] low_selector_switch_bank, // Low contacts.
  input wire logic                         high_selector_switch,     // High contact.
  input wire logic [AXIS_INDEX_WIDTH-1:0]  axis_position,            // Position strap.
  input wire logic [7:0]                   node_identifier,          // Active identifier.
  input wire logic                         protocol_vendor_can,      // Protocol choice.
  input wire logic                         lss_inactive,             // LSS inactive.
  input wire logic [15:0]                  station_alias,            // Station alias.
  input wire logic                         config_done,              // Decode finished.
  input wire logic                         s_axi_arvalid,            // Read address valid.
  input wire logic                         s_axi_arready,            // Read address ready.
  input wire logic                         s_axi_rvalid              // Read data valid.
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_reset_default;
    $rose(aresetn) |-> node_identifier == 8'hFF && !config_done && lss_inactive;
  endproperty
  a_reset_default: assert property (p_reset_default)
    else $error("Outputs not at defaults after reset.");

  property p_done_holds;
    config_done |=> config_done;
  endproperty
  a_done_holds: assert property (p_done_holds)
    else $error("Decode finished flag dropped.");

  // The sample is taken before the flag rises, so one cycle after the rise the identifier must match the contacts.
  property p_hw_decode;
    $rose(config_done) |-> ##1 node_identifier == {high_selector_switch, low_selector_switch_bank[0],
      low_selector_switch_bank[1], low_selector_switch_bank[2], low_selector_switch_bank[3], axis_position};
  endproperty
  a_hw_decode: assert property (p_hw_decode)
    else $error("Switch decode wrong at power-up.");

  property p_protocol;
    $rose(config_done) |-> ##1 protocol_vendor_can == high_selector_switch;
  endproperty
  a_protocol: assert property (p_protocol)
    else $error("Protocol choice wrong.");

  property p_alias_follows;
    config_done && $stable(node_identifier) && node_identifier != 8'hFF |-> station_alias == {8'h00, node_identifier};
  endproperty
  a_alias_follows: assert property (p_alias_follows)
    else $error("Alias differs from identifier.");

  property p_alias_default;
    $stable(node_identifier) && node_identifier == 8'hFF |-> station_alias == 16'h0000;
  endproperty
  a_alias_default: assert property (p_alias_default)
    else $error("Alias not zero for default identifier.");

  property p_lss_canopen;
    config_done && $stable(node_identifier) && node_identifier == 8'hFF && !protocol_vendor_can |-> lss_inactive;
  endproperty
  a_lss_canopen: assert property (p_lss_canopen)
    else $error("LSS inactive missing.");

  property p_lss_only_default;
    config_done && $stable(node_identifier) && node_identifier != 8'hFF |-> !lss_inactive;
  endproperty
  a_lss_only_default: assert property (p_lss_only_default)
    else $error("LSS inactive with a real identifier.");

  property p_no_zero_id;
    config_done |-> node_identifier != 8'h00;
  endproperty
  a_no_zero_id: assert property (p_no_zero_id)
    else $error("Identifier zero.");

  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("Read answer late.");
endmodule // axis_id_power_up_select_properties

bind axis_id_power_up_select axis_id_power_up_select_properties #(
  .SWITCH_BANK_WIDTH(SWITCH_BANK_WIDTH),
  .AXIS_INDEX_WIDTH (AXIS_INDEX_WIDTH)
) props (.aclk, .aresetn, .low_selector_switch_bank, .high_selector_switch, .axis_position,
  .node_identifier, .protocol_vendor_can, .lss_inactive, .station_alias, .config_done,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

`default_nettype wire

// ===== switch_bank_model.sv
`timescale 1ns/1ps
`default_nettype none

module switch_bank_model (
  input  wire logic       aclk,     // Contacts move just after this edge.
  input  wire logic [4:0] code,     // Wanted code, high contact first, contact 4 last.
  input  wire logic [2:0] pos,      // Wanted axis position.
  output logic [3:0]      bank,     // Contacts 1..4 in bits 0..3, on = 1.
  output logic            high,     // High contact, on = 1.
  output logic [2:0]      position  // Position strap.
);
  // Contact 1 weighs more than contact 4, so the low bank is the code reversed.
  always @(posedge aclk) begin
    high <= code[4];
    bank <= {code[0], code[1], code[2], code[3]};
    position <= pos;
  end
endmodule // switch_bank_model

`default_nettype wire

// ===== axis_id_power_up_select_bench.sv
`timescale 1ns/1ps
`default_nettype none

module axis_id_power_up_select_bench;
  logic        aclk, aresetn, high_selector_switch, protocol_vendor_can, lss_inactive, config_done;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [2:0]  axis_position, sw_pos;
  logic [3:0]  low_selector_switch_bank, s_axi_wstrb;
  logic [4:0]  sw_code;
  logic [7:0]  node_identifier, s_axi_awaddr, s_axi_araddr;
  logic [15:0] station_alias;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [4:0]  codes [4] = '{5'h1F, 5'h10, 5'h0A, 5'h00};
  int          err_total, checks_done;

  axis_id_power_up_select uut (.*);
  switch_bank_model far (.aclk(aclk), .code(sw_code), .pos(sw_pos), .bank(low_selector_switch_bank),
    .high(high_selector_switch), .position(axis_position));

  initial begin
    aclk = 1'h0;
    forever #4 aclk = ~aclk;
  end

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask

  task automatic axi_read(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    rdat = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask

  // The outputs settle one cycle after the commit, so four spare edges are ample.
  task automatic apply;
    axi_write(node_id_pkg::COMMAND_OFFSET, 32'h0000_0001, 4'hF);
    repeat (4) @(posedge aclk);
  endtask

  task automatic power_up(input logic [4:0] c, input logic [2:0] p);
    aresetn <= 1'h0;
    sw_code <= c;
    sw_pos <= p;
    repeat (20) @(posedge aclk);
    chk({config_done, lss_inactive, station_alias, node_identifier}, 32'h0100_00FF);
    aresetn <= 1'h1;
    do begin
      @(posedge aclk);
    end while (config_done !== 1'h1);
    @(posedge aclk);
    chk(node_identifier, {c, p});
    chk(protocol_vendor_can, c[4]);
    chk(station_alias, {c, p});
    chk(lss_inactive, 1'h0);
  endtask

  task automatic final_report;
    if (err_total == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial begin
    aresetn = 1'h0;
    sw_code = 5'h00;
    sw_pos = 3'h1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 52'h0;
    err_total = 0;
    checks_done = 0;
    @(posedge aclk);
    for (int i = 0; i < 4; i++) power_up(codes[i], 3'(4 - i));
    sw_code <= 5'h15;
    sw_pos <= 3'h2;
    repeat (8) @(posedge aclk);
    apply();
    chk(node_identifier, 8'h01);
    axi_read(node_id_pkg::SAMPLE_OFFSET);
    chk(rdat, 32'h0000_0800);
    axi_write(node_id_pkg::SETUP_OFFSET, 32'h0000_0002, 4'hF);
    apply();
    chk({lss_inactive, station_alias, node_identifier}, 32'h0100_00FF);
    axi_read(node_id_pkg::STATUS_OFFSET);
    chk(rdat, 32'h0000_FF05);
    axi_write(node_id_pkg::SETUP_OFFSET, 32'h0000_C802, 4'hF);
    apply();
    chk(station_alias, 16'h00C8);
    axi_write(node_id_pkg::SETUP_OFFSET, 32'h0000_0003, 4'h1);
    axi_read(node_id_pkg::SETUP_OFFSET);
    chk(rdat, 32'h0000_C803);
    apply();
    chk(node_identifier, 8'h01);
    axi_write(node_id_pkg::STATUS_OFFSET, 32'h0000_FFFF, 4'hF);
    chk(rsp, node_id_pkg::RESP_SLVERR);
    axi_read(8'h14);
    chk(rsp, node_id_pkg::RESP_SLVERR);
    chk(rdat, 32'h0000_0000);
    // The default identifier under the vendor protocol must not leave the LSS inactive flag set.
    power_up(5'h10, 3'h1);
    axi_write(node_id_pkg::SETUP_OFFSET, 32'h0000_0002, 4'hF);
    apply();
    chk({lss_inactive, station_alias, node_identifier}, 32'h0000_00FF);
    final_report();
  end

  initial begin
    repeat (5000) @(posedge aclk);
    err_total++;
    final_report();
  end
endmodule // axis_id_power_up_select_bench

`default_nettype wire
